/* logic/burst_cfg_ctrl.sv */
// controller end: issues legal mode-register writes and bursts
`timescale 1ns/1ps
module burst_cfg_ctrl (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           ce,
  burst_cfg_if.ctrl           link,
  input  wire logic           x32_org,
  input  wire logic           cfg_req,
  input  wire logic [2:0]     cfg_burst_length,
  input  wire logic           cfg_interleave,
  input  wire logic           cfg_no_wrap,
  input  wire logic [2:0]     cfg_write_recovery,
  input  wire logic           lat_req,
  input  wire logic [3:0]     cfg_latency,
  input  wire logic           rd_req,
  input  wire logic [7:0]     rd_addr,
  input  wire logic           burst_req,
  input  wire logic [10:0]    burst_col,
  input  wire logic           burst_write,
  input  wire logic           burst_ap,
  output logic                req_refused
);
  import burst_cfg_pkg::*;

  cmd_type      cmd_ff, nxt_cmd;
  logic [7:0]   addr_ff, nxt_addr;
  logic [7:0]   wdata_ff, nxt_wdata;
  logic [10:0]  col_ff, nxt_col;
  logic         wr_ff, nxt_wr;
  logic         ap_ff, nxt_ap;
  logic         ref_ff, nxt_ref;
  logic         cfg_ok, lat_ok, col_ok;
  logic         nowrap_ff, nxt_nowrap;
  logic [10:0]  colm;

  always_comb begin
    cfg_ok = cfg_burst_length >= bl4_code && cfg_burst_length <= bl16_code &&
             cfg_write_recovery >= wr_code_min && cfg_write_recovery <= wr_code_max &&
             !(cfg_burst_length == bl16_code && cfg_interleave) &&
             !(cfg_no_wrap && cfg_burst_length != bl4_code);
    lat_ok = cfg_latency >= lat_code_min && cfg_latency <= lat_code_max;
    colm   = {burst_col[10:1], 1'b0} & (x32_org ? x32_col_mask : x16_col_mask);
    col_ok = 1'b1;
    if (nowrap_ff) begin
      if (colm <= low_start_last) col_ok = 1'b0;
      if (!x32_org && colm >= x16_page_last) col_ok = 1'b0;
      if (x32_org && colm >= x32_page_last) col_ok = 1'b0;
      if (!x32_org && colm >= x16_subpage_lo && colm <= x16_subpage_hi) begin
        col_ok = 1'b0;
      end
    end
  end

  always_comb begin
    nxt_cmd   = cmd_idle;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_col   = col_ff;
    nxt_wr    = wr_ff;
    nxt_ap    = ap_ff;
    nxt_ref   = 1'b0;
    nxt_nowrap = nowrap_ff;
    if (link.busy || cmd_ff != cmd_idle) begin
      nxt_ref = cfg_req | lat_req | rd_req | burst_req;
    end else if (cfg_req) begin
      if (cfg_ok) begin
        nxt_cmd   = cmd_mrw;
        nxt_addr  = burst_reg_addr;
        nxt_wdata = {cfg_write_recovery, cfg_no_wrap, cfg_interleave, cfg_burst_length};
        nxt_nowrap = cfg_no_wrap;
      end else begin
        nxt_ref = 1'b1;
      end
    end else if (lat_req) begin
      if (lat_ok) begin
        nxt_cmd   = cmd_mrw;
        nxt_addr  = latency_reg_addr;
        nxt_wdata = {4'h0, cfg_latency};
      end else begin
        nxt_ref = 1'b1;
      end
    end else if (rd_req) begin
      nxt_cmd  = cmd_mrr;
      nxt_addr = rd_addr;
    end else if (burst_req) begin
      if (col_ok) begin
        nxt_cmd = cmd_burst;
        nxt_col = burst_col;
        nxt_wr  = burst_write;
        nxt_ap  = burst_ap;
      end else begin
        nxt_ref = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_ff    <= cmd_idle;
      addr_ff   <= 8'h00;
      wdata_ff  <= 8'h00;
      col_ff    <= 11'h000;
      wr_ff     <= 1'b0;
      ap_ff     <= 1'b0;
      ref_ff    <= 1'b0;
      nowrap_ff <= 1'b0;
    end else if (ce) begin
      cmd_ff    <= nxt_cmd;
      addr_ff   <= nxt_addr;
      wdata_ff  <= nxt_wdata;
      col_ff    <= nxt_col;
      wr_ff     <= nxt_wr;
      ap_ff     <= nxt_ap;
      ref_ff    <= nxt_ref;
      nowrap_ff <= nxt_nowrap;
    end
  end

  assign link.cmd            = cmd_ff;
  assign link.addr           = addr_ff;
  assign link.wdata          = wdata_ff;
  assign link.col            = col_ff;
  assign link.write          = wr_ff;
  assign link.auto_precharge = ap_ff;
  assign req_refused         = ref_ff;
endmodule : burst_cfg_ctrl

/* logic/burst_cfg_device.sv */
// device end: feature registers, burst sequencer and write recovery
//
// Contract
// - burst config held in write-only register 01
// - bit 3 selects sequential or interleaved
// - bit 4 wrap control, no wrap BL4 only
// - bits 7:5 write recovery three to eight
// - write auto-precharge waits programmed recovery cycles, read auto-precharge starts on the last beat
// - controller never pairs BL16 with interleaved
// - column bit 0 forced to zero
// - sequential BL8 increments modulo eight
// - interleaved BL8 is start xor beat
// - sequential BL16 increments modulo sixteen
// - no-wrap BL4 counts linearly
// - controller avoids page-end no-wrap starts
// - x16 controller avoids sub-page straddling starts
// - latency register 02, bits 3:0 used
// - controller writes reserved bits as zero
// - reads of write-only registers still strobe
// - latency codes one to six decoded
`timescale 1ns/1ps
module burst_cfg_device (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           ce,
  burst_cfg_if.dev            link,
  output logic      [10:0]    col_addr,
  output logic                col_valid,
  output logic                col_write,
  output logic                precharge_start,
  output logic      [3:0]     read_latency,
  output logic      [2:0]     write_latency,
  output logic      [3:0]     write_recovery,
  output logic                config_error
);
  import burst_cfg_pkg::*;

  logic [7:0]         burst_cfg_ff, nxt_burst_cfg;
  logic [7:0]         lat_cfg_ff, nxt_lat_cfg;
  logic               err_ff, nxt_err;
  seq_state_type      state_ff, nxt_state;
  logic [3:0]         beat_ff, nxt_beat;
  logic [3:0]         rec_ff, nxt_rec;
  logic [10:0]        start_ff, nxt_start;
  logic               wr_ff, nxt_wr;
  logic               ap_ff, nxt_ap;
  logic [10:0]        col_ff, nxt_col;
  logic               valid_ff, nxt_valid;
  logic               colw_ff, nxt_colw;
  logic               pre_ff, nxt_pre;
  logic               rstb_ff, nxt_rstb;
  logic [3:0]         rl_ff, nxt_rl;
  logic [2:0]         wl_ff, nxt_wl;
  logic [3:0]         nwr_ff, nxt_nwr;
  logic               busy_ff, nxt_busy;
  logic [10:0]        order_col;
  logic [3:0]         beats_last;
  logic [2:0]         bl_f, wr_f;
  logic [3:0]         lat_f;

  assign bl_f  = burst_cfg_ff[bl_pos +: 3];
  assign wr_f  = burst_cfg_ff[wr_pos +: 3];
  assign lat_f = lat_cfg_ff[3:0];

  burst_order u_order (
    .start_col          (start_ff),
    .beat               (beat_ff),
    .burst_length_field (bl_f),
    .burst_type_bit     (burst_cfg_ff[bt_pos]),
    .wrap_control_bit   (burst_cfg_ff[wc_pos]),
    .col                (order_col)
  );

  always_comb begin
    case (bl_f)
      bl8_code:  beats_last = bl8_last_beat;
      bl16_code: beats_last = bl16_last_beat;
      default:   beats_last = bl4_last_beat;
    endcase
  end

  // register file; mode-register commands are refused unless the sequencer is idle (mid-burst or in recovery)
  always_comb begin
    nxt_burst_cfg = burst_cfg_ff;
    nxt_lat_cfg   = lat_cfg_ff;
    nxt_err       = err_ff;
    nxt_rstb      = 1'b0;
    if (state_ff == st_idle && link.cmd == cmd_mrw) begin
      if (link.addr == burst_reg_addr) begin
        nxt_burst_cfg = link.wdata;
        // reserved codes are stored but flagged
        if (link.wdata[2:0] < bl4_code || link.wdata[2:0] > bl16_code ||
            link.wdata[7:5] < wr_code_min || link.wdata[7:5] > wr_code_max ||
            (link.wdata[4] && link.wdata[2:0] != bl4_code)) begin
          nxt_err = 1'b1;
        end
      end else if (link.addr == latency_reg_addr) begin
        nxt_lat_cfg = {4'h0, link.wdata[3:0]};
        if (link.wdata[3:0] < lat_code_min || link.wdata[3:0] > lat_code_max) begin
          nxt_err = 1'b1;
        end
      end
    end
    if (state_ff == st_idle && link.cmd == cmd_mrr) begin
      nxt_rstb = 1'b1;
    end
  end

  // latency and recovery decode
  always_comb begin
    nxt_nwr = {1'b0, wr_f} + wr_code_offset;
    nxt_rl  = lat_f + wr_code_offset;
    case (lat_f)
      4'h1:    nxt_wl = 3'h1;
      4'h2:    nxt_wl = 3'h2;
      4'h3:    nxt_wl = 3'h2;
      4'h4:    nxt_wl = 3'h3;
      4'h5:    nxt_wl = 3'h4;
      4'h6:    nxt_wl = 3'h4;
      default: nxt_wl = 3'h0;
    endcase
  end

  // burst sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_beat  = beat_ff;
    nxt_rec   = rec_ff;
    nxt_start = start_ff;
    nxt_wr    = wr_ff;
    nxt_ap    = ap_ff;
    nxt_col   = col_ff;
    nxt_valid = 1'b0;
    nxt_colw  = colw_ff;
    nxt_pre   = 1'b0;
    case (state_ff)
      st_idle: begin
        if (link.cmd == cmd_burst) begin
          nxt_start = {link.col[10:1], 1'b0};
          nxt_wr    = link.write;
          nxt_ap    = link.auto_precharge;
          nxt_beat  = 4'h0;
          nxt_state = st_burst;
        end
      end
      st_burst: begin
        nxt_col   = order_col;
        nxt_colw  = wr_ff;
        nxt_valid = 1'b1;
        nxt_beat  = beat_ff + 4'h1;
        if (beat_ff == beats_last) begin
          if (wr_ff && ap_ff) begin
            nxt_rec   = nwr_ff;
            nxt_state = st_rec;
          end else begin
            nxt_pre   = ap_ff;
            nxt_state = st_idle;
          end
        end
      end
      st_rec: begin
        nxt_rec = rec_ff - 4'h1;
        if (rec_ff == 4'h1) begin
          nxt_pre   = 1'b1;
          nxt_state = st_idle;
        end
      end
      default: nxt_state = st_idle;
    endcase
    // registered so the link sees busy straight from a flop
    nxt_busy = (nxt_state != st_idle);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      burst_cfg_ff <= burst_reset_value;
      lat_cfg_ff   <= lat_reset_value;
      err_ff       <= 1'b0;
      state_ff     <= st_idle;
      beat_ff      <= 4'h0;
      rec_ff       <= 4'h0;
      start_ff     <= 11'h000;
      wr_ff        <= 1'b0;
      ap_ff        <= 1'b0;
      col_ff       <= 11'h000;
      valid_ff     <= 1'b0;
      colw_ff      <= 1'b0;
      pre_ff       <= 1'b0;
      rstb_ff      <= 1'b0;
      rl_ff        <= rl_reset_value;
      wl_ff        <= wl_reset_value;
      nwr_ff       <= nwr_reset_value;
      busy_ff      <= 1'b0;
    end else if (ce) begin
      burst_cfg_ff <= nxt_burst_cfg;
      lat_cfg_ff   <= nxt_lat_cfg;
      err_ff       <= nxt_err;
      state_ff     <= nxt_state;
      beat_ff      <= nxt_beat;
      rec_ff       <= nxt_rec;
      start_ff     <= nxt_start;
      wr_ff        <= nxt_wr;
      ap_ff        <= nxt_ap;
      col_ff       <= nxt_col;
      valid_ff     <= nxt_valid;
      colw_ff      <= nxt_colw;
      pre_ff       <= nxt_pre;
      rstb_ff      <= nxt_rstb;
      rl_ff        <= nxt_rl;
      wl_ff        <= nxt_wl;
      nwr_ff       <= nxt_nwr;
      busy_ff      <= nxt_busy;
    end
  end

  // write-only registers: read data is don't-care, driven as zero
  assign link.rdata     = 8'h00;
  assign link.rd_strobe = rstb_ff;
  assign link.busy      = busy_ff;
  assign col_addr        = col_ff;
  assign col_valid       = valid_ff;
  assign col_write       = colw_ff;
  assign precharge_start = pre_ff;
  assign read_latency    = rl_ff;
  assign write_latency   = wl_ff;
  assign write_recovery  = nwr_ff;
  assign config_error    = err_ff;
endmodule : burst_cfg_device

/* logic/burst_cfg_if.sv */
// command link between memory controller and device sequencer
`timescale 1ns/1ps
interface burst_cfg_if;
  import burst_cfg_pkg::*;
  cmd_type     cmd;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [10:0] col;
  logic        write;
  logic        auto_precharge;
  logic        busy;
  logic        rd_strobe;
  logic [7:0]  rdata;
  modport ctrl (output cmd, addr, wdata, col, write, auto_precharge,
                input busy, rd_strobe, rdata);
  modport dev (input cmd, addr, wdata, col, write, auto_precharge,
               output busy, rd_strobe, rdata);
endinterface : burst_cfg_if

/* logic/burst_cfg_pkg.sv */
// shared constants and types for the burst configuration link
package burst_cfg_pkg;
  localparam logic [7:0] burst_reg_addr    = 8'h01;
  localparam logic [7:0] latency_reg_addr  = 8'h02;
  localparam logic [2:0] bl_pos            = 3'h0;
  localparam logic [2:0] bt_pos            = 3'h3;
  localparam logic [2:0] wc_pos            = 3'h4;
  localparam logic [2:0] wr_pos            = 3'h5;
  localparam logic [2:0] bl4_code          = 3'h2;
  localparam logic [2:0] bl8_code          = 3'h3;
  localparam logic [2:0] bl16_code         = 3'h4;
  localparam logic [2:0] wr_code_min       = 3'h1;
  localparam logic [2:0] wr_code_max       = 3'h6;
  localparam logic [3:0] wr_code_offset    = 4'h2;
  localparam logic [3:0] lat_code_min      = 4'h1;
  localparam logic [3:0] lat_code_max      = 4'h6;
  localparam logic [7:0] burst_reset_value = 8'h22;
  localparam logic [7:0] lat_reset_value   = 8'h01;
  localparam logic [10:0] x16_page_last    = 11'h7fe;
  localparam logic [10:0] x16_subpage_lo   = 11'h3fe;
  localparam logic [10:0] x16_subpage_hi   = 11'h401;
  localparam logic [10:0] x32_page_last    = 11'h3fe;
  localparam logic [10:0] low_start_last   = 11'h001;
  localparam logic [10:0] x16_col_mask     = 11'h7ff;
  localparam logic [10:0] x32_col_mask     = 11'h3ff;
  localparam logic [3:0] bl4_last_beat     = 4'h3;
  localparam logic [3:0] bl8_last_beat     = 4'h7;
  localparam logic [3:0] bl16_last_beat    = 4'hf;
  localparam logic [3:0] rl_reset_value    = 4'h3;
  localparam logic [2:0] wl_reset_value    = 3'h1;
  localparam logic [3:0] nwr_reset_value   = 4'h3;

  typedef enum logic [1:0] {
    cmd_idle  = 2'b00,
    cmd_mrw   = 2'b01,
    cmd_mrr   = 2'b10,
    cmd_burst = 2'b11
  } cmd_type;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_burst = 2'b01,
    st_rec   = 2'b10
  } seq_state_type;
endpackage : burst_cfg_pkg

/* logic/burst_order.sv */
// column order generator for one beat of a burst
`timescale 1ns/1ps
module burst_order (
  input  wire logic [10:0] start_col,
  input  wire logic [3:0]  beat,
  input  wire logic [2:0]  burst_length_field,
  input  wire logic        burst_type_bit,
  input  wire logic        wrap_control_bit,
  output logic      [10:0] col
);
  import burst_cfg_pkg::*;
  logic [10:0] base;
  always_comb begin
    base = {start_col[10:1], 1'b0};
    col  = base;
    if (wrap_control_bit) begin
      col = base + {7'h00, beat};
    end else if (burst_length_field == bl16_code) begin
      col = {base[10:4], base[3:0] + beat};
    end else if (burst_length_field == bl8_code) begin
      if (burst_type_bit) begin
        col = {base[10:3], base[2:0] ^ beat[2:0]};
      end else begin
        col = {base[10:3], base[2:0] + beat[2:0]};
      end
    end else begin
      col = {base[10:2], base[1:0] + beat[1:0]};
    end
  end
endmodule : burst_order

/* tb/burst_cfg_asserts.sv */
// concurrent checks on the controller to device command link
`timescale 1ns/1ps
module burst_cfg_asserts (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire burst_cfg_pkg::cmd_type cmd,
  input wire logic [7:0]             addr,
  input wire logic [7:0]             wdata,
  input wire logic                   busy,
  input wire logic                   rd_strobe,
  input wire logic [7:0]             rdata
);
  import burst_cfg_pkg::*;
  logic mrw_b;
  logic mrw_l;
  assign mrw_b = (cmd == cmd_mrw) && (addr == burst_reg_addr);
  assign mrw_l = (cmd == cmd_mrw) && (addr == latency_reg_addr);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_cmd_one_cycle: assert property (cmd != cmd_idle |=> cmd == cmd_idle)
    else $error("command held longer than one cycle");
  a_burst_sets_busy: assert property (cmd == cmd_burst |=> busy)
    else $error("burst did not raise busy");
  // longest case is sixteen beats plus eight recovery cycles
  a_busy_ends: assert property ($rose(busy) |-> ##[1:40] !busy)
    else $error("busy never dropped");
  a_mr_not_busy: assert property (busy |-> !(cmd inside {cmd_mrw, cmd_mrr}))
    else $error("mode register command while busy");
  a_read_strobes: assert property (cmd == cmd_mrr |=> rd_strobe)
    else $error("read without strobe");
  a_strobe_cause: assert property (rd_strobe |-> $past(cmd) == cmd_mrr)
    else $error("strobe without read");
  a_rdata_zero: assert property (rd_strobe |-> rdata == 8'h00)
    else $error("read data not zero");
  a_lat_legal: assert property (mrw_l |-> wdata[7:4] == 4'h0 && wdata[3:0] inside {[1:6]})
    else $error("bad latency write");
  a_burst_legal: assert property (mrw_b |-> wdata[2:0] inside {[2:4]} && wdata[7:5] inside {[1:6]})
    else $error("reserved burst field written");
  a_no_bl16_int: assert property (mrw_b && wdata[2:0] == bl16_code |-> !wdata[3])
    else $error("sixteen beats with interleave");
  a_nowrap_bl4: assert property (mrw_b && wdata[4] |-> wdata[2:0] == bl4_code)
    else $error("no wrap with long burst");
endmodule : burst_cfg_asserts

/* tb/dram_burst_config_sequencer_tb.sv */
// self-checking bench joining controller and device ends
`timescale 1ns/1ps
module dram_burst_config_sequencer_tb;
  import burst_cfg_pkg::*;
  logic        clk, rst, ce, x32_org, cfg_req, cfg_interleave, cfg_no_wrap, lat_req;
  logic        rd_req, burst_req, burst_write, burst_ap, req_refused;
  logic [2:0]  cfg_burst_length, cfg_write_recovery, write_latency;
  logic [3:0]  cfg_latency, read_latency, write_recovery;
  logic [7:0]  rd_addr;
  logic [10:0] burst_col, col_addr;
  logic        col_valid, col_write, precharge_start, config_error;
  logic [15:0] ref_n, pre_n, str_n;
  int          error_cnt, check_count, cyc, last_beat, pre_at;
  int          m_bl, m_bt, m_nw, m_wr, m_rl, m_wl;
  int          rl_tab[6] = '{3, 4, 5, 6, 7, 8};
  int          wl_tab[6] = '{1, 2, 2, 3, 4, 4};
  logic [10:0] nw16[11] = '{11'h7fe, 11'h7ff, 11'h000, 11'h001, 11'h3fe, 11'h3ff,
                            11'h400, 11'h401, 11'h3fc, 11'h7fc, 11'h3fa};
  logic [10:0] nw32[6] = '{11'h3fe, 11'h3ff, 11'h000, 11'h001, 11'h3fa, 11'h002};
  logic [10:0] beats[$];
  logic        wr_q[$];

  burst_cfg_if link_if ();
  burst_cfg_device u_burst_cfg_device (.clk(clk), .rst(rst), .ce(ce), .link(link_if),
    .col_addr(col_addr), .col_valid(col_valid), .col_write(col_write),
    .precharge_start(precharge_start), .read_latency(read_latency),
    .write_latency(write_latency), .write_recovery(write_recovery),
    .config_error(config_error));
  burst_cfg_ctrl u_burst_cfg_ctrl (.clk(clk), .rst(rst), .ce(ce), .link(link_if),
    .x32_org(x32_org), .cfg_req(cfg_req), .cfg_burst_length(cfg_burst_length),
    .cfg_interleave(cfg_interleave), .cfg_no_wrap(cfg_no_wrap),
    .cfg_write_recovery(cfg_write_recovery), .lat_req(lat_req), .cfg_latency(cfg_latency),
    .rd_req(rd_req), .rd_addr(rd_addr), .burst_req(burst_req), .burst_col(burst_col),
    .burst_write(burst_write), .burst_ap(burst_ap), .req_refused(req_refused));
  burst_cfg_asserts chk (.clk(clk), .rst(rst), .cmd(link_if.cmd), .addr(link_if.addr),
    .wdata(link_if.wdata), .busy(link_if.busy), .rd_strobe(link_if.rd_strobe),
    .rdata(link_if.rdata));

  always #2.5 clk = ~clk;

  // reads outputs in the active region, before the design's updates land
  always @(posedge clk) begin
    cyc++;
    if (col_valid === 1'b1) begin
      beats.push_back(col_addr);
      wr_q.push_back(col_write);
      last_beat = cyc;
    end
    if (precharge_start === 1'b1) begin
      pre_n++;
      pre_at = cyc;
    end
    if (req_refused === 1'b1) ref_n++;
    if (link_if.rd_strobe === 1'b1) str_n++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // clears the request lines after one edge, then a bounded wait until the link is idle again
  task automatic fire();
    @(posedge clk);
    #1;
    cfg_req = 1'b0;
    lat_req = 1'b0;
    rd_req = 1'b0;
    burst_req = 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 60 && link_if.busy !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
  endtask : fire

  task automatic clear();
    ref_n = 16'h0;
    pre_n = 16'h0;
    str_n = 16'h0;
    beats.delete();
    wr_q.delete();
  endtask : clear

  function automatic logic [10:0] exp_col(input logic [10:0] s, input int i);
    logic [10:0] b;
    b = s & 11'h7fe;
    if (m_nw != 0) return b + 11'(i);
    if (m_bl == 4) return {b[10:2], 2'(b[1:0] + i)};
    if (m_bl == 8 && m_bt != 0) return {b[10:3], b[2:0] ^ 3'(i)};
    if (m_bl == 8) return {b[10:3], 3'(b[2:0] + i)};
    return {b[10:4], 4'(b[3:0] + i)};
  endfunction : exp_col

  function automatic logic nw_bad(input logic [10:0] s);
    if (x32_org) return s[9:0] <= 10'h001 || s[9:0] >= 10'h3fe;
    return s <= 11'h001 || s >= 11'h7fe || (s >= 11'h3fe && s <= 11'h401);
  endfunction : nw_bad

  task automatic do_cfg(input logic [2:0] bl, input logic bt, nw, input logic [2:0] wr);
    logic bad;
    bad = !(bl inside {[2:4]}) || wr == 3'h0 || wr == 3'h7 || (bl == 3'h4 && bt) ||
          (nw && bl != 3'h2);
    clear();
    cfg_burst_length = bl;
    cfg_interleave = bt;
    cfg_no_wrap = nw;
    cfg_write_recovery = wr;
    cfg_req = 1'b1;
    fire();
    check(ref_n, 16'(bad));
    if (!bad) begin
      m_bl = 4 << (bl - 3'h2);
      m_bt = bt;
      m_nw = nw;
      m_wr = wr + 2;
    end
    check(write_recovery, 16'(m_wr));
  endtask : do_cfg

  task automatic do_burst(input logic [10:0] s, input logic w, ap);
    logic bad;
    bad = m_nw != 0 && nw_bad(s);
    clear();
    burst_col = s;
    burst_write = w;
    burst_ap = ap;
    burst_req = 1'b1;
    fire();
    check(ref_n, 16'(bad));
    check(16'(beats.size()), bad ? 16'h0 : 16'(m_bl));
    foreach (beats[i]) begin
      check(beats[i], exp_col(s, i));
      check(wr_q[i], w);
    end
    check(pre_n, 16'(!bad && ap));
    // read precharge rides on the last beat; write waits the recovery count
    if (!bad && ap) check(16'(pre_at - last_beat), 16'(w ? m_wr : 0));
  endtask : do_burst

  task automatic do_lat(input logic [3:0] c);
    logic bad;
    bad = c < 4'h1 || c > 4'h6;
    clear();
    cfg_latency = c;
    lat_req = 1'b1;
    fire();
    check(ref_n, 16'(bad));
    if (!bad) begin
      m_rl = rl_tab[c - 4'h1];
      m_wl = wl_tab[c - 4'h1];
    end
    check(read_latency, 16'(m_rl));
    check(write_latency, 16'(m_wl));
  endtask : do_lat

  initial begin
    {clk, ce, x32_org, cfg_req, cfg_interleave, cfg_no_wrap, lat_req, rd_req} = '0;
    {burst_req, burst_write, burst_ap, cfg_burst_length, cfg_write_recovery} = '0;
    {cfg_latency, rd_addr, burst_col} = '0;
    rst = 1'b1;
    ce = 1'b1;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    void'($urandom(78319));
    m_bl = 4;
    m_bt = 0;
    m_nw = 0;
    m_wr = 3;
    m_rl = 3;
    m_wl = 1;
    clear();
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    check(write_recovery, 16'h3);
    check(read_latency, 16'h3);
    check(write_latency, 16'h1);
    do_burst(11'h7fb, 1'b1, 1'b1);
    foreach (nw32[i]) begin
      if (i < 2) begin
        clear();
        rd_addr = i == 0 ? burst_reg_addr : latency_reg_addr;
        rd_req = 1'b1;
        fire();
        check(str_n, 16'h1);
      end
    end
    // frozen clock enable must swallow a request
    clear();
    ce = 1'b0;
    cfg_burst_length = bl8_code;
    cfg_write_recovery = 3'h6;
    cfg_req = 1'b1;
    fire();
    ce = 1'b1;
    check(ref_n, 16'h0);
    check(write_recovery, 16'(m_wr));
    for (int b = 0; b < 8; b++) begin
      for (int t = 0; t < 4; t++) begin
        do_cfg(3'(b), t[0], t[1], 3'($urandom_range(7)));
        do_burst(11'($urandom), 1'($urandom), 1'($urandom));
      end
    end
    for (int w = 0; w < 8; w++) begin
      do_cfg(bl8_code, 1'b0, 1'b0, 3'(w));
      do_burst(11'($urandom), 1'b1, 1'b1);
    end
    do_cfg(bl4_code, 1'b0, 1'b1, 3'h1);
    foreach (nw16[i]) do_burst(nw16[i], 1'b0, 1'b0);
    // page size shrinks for the wide organisation
    x32_org = 1'b1;
    foreach (nw32[i]) do_burst(nw32[i], 1'b1, 1'b0);
    x32_org = 1'b0;
    for (int c = 0; c < 16; c++) do_lat(4'(c));
    // mid-run reset must bring back the default configuration
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    m_bl = 4;
    m_bt = 0;
    m_nw = 0;
    m_wr = 3;
    m_rl = 3;
    m_wl = 1;
    check(write_recovery, 16'h3);
    check(read_latency, 16'h3);
    check(write_latency, 16'h1);
    do_burst(11'($urandom), 1'b1, 1'b1);
    check(config_error, 16'h0);
    give_verdict();
  end
endmodule : dram_burst_config_sequencer_tb
